// file: src/spf_format.sv
`timescale 1ns/1ps
`include "spf_map.svh"

// Overview of operation
// - Decoder output samples are 13 bits left-justified in 16 bits with the three LSBs zero.
// - The first two ratio codes are 6 bits and the third and fourth 5 bits, right-justified.
// - The fifth and sixth ratio codes are 4 bits and the seventh and eighth 3 bits.
// - A frame is eight ratio codes then four subframes, each opening with 7-bit lag, 2-bit gain.
// - Each subframe carries a 2-bit right-justified grid position code.
// - Each subframe carries a 6-bit right-justified block amplitude code.
// - Each subframe carries thirteen 3-bit right-justified pulse codes numbered 0 to 12.
// - The decoder takes any lag code from 0 to 127 and keeps running deterministically.
// - The decoder takes every value that each field width allows.
// - One frame is 20 ms of signal and exactly 76 coded words at both ends.
// - Samples flow continuously at 8 kHz and one frame is exchanged every 20 ms.
module spf_format #(
  parameter int SAMPLE_CYCLES = `SPF_SAMPLE_PERIOD_NS / `SPF_CLK_PERIOD_NS
) (
  input  wire logic              mclk_i,
  input  wire logic              reset_n_i,
  input  wire logic              enc_sample_valid_i,
  input  wire logic [15:0]       enc_sample_i,
  input  wire logic              encp_valid_i,
  input  wire logic [15:0]       encp_code_i,
  input  wire logic              decp_valid_i,
  input  wire logic [15:0]       decp_word_i,
  input  wire logic              synth_valid_i,
  input  wire logic [15:0]       synth_sample_i,
  output logic                   enc_lin_valid_o,
  output logic [12:0]            enc_linear_o,
  output logic                   enc_lsb_err_o,
  output logic                   encp_valid_o,
  output logic [15:0]            encp_word_o,
  output logic                   encp_last_o,
  output logic                   dec_valid_o,
  output spf_pkg::spf_kind_t     dec_kind_o,
  output logic [1:0]             dec_sub_o,
  output logic [3:0]             dec_slot_o,
  output logic [6:0]             dec_value_o,
  output logic                   dec_last_o,
  output logic                   lag_bad_o,
  output logic                   pcm_valid_o,
  output logic [15:0]            pcm_o,
  output logic                   frame_start_o
);
  import spf_pkg::*;

  // position of a word inside its subframe
  function automatic logic [6:0] pos_of(input logic [6:0] idx);
    pos_of = 7'((idx - `SPF_LAR_WORDS) % `SPF_SUB_WORDS);
  endfunction
  function automatic spf_kind_t kind_of(input logic [6:0] idx);
    if (idx < `SPF_LAR_WORDS) begin
      kind_of = SPF_LAR;
    end else begin
      case (pos_of(idx))
        `SPF_POS_LAG:  kind_of = SPF_LAG;
        `SPF_POS_GAIN: kind_of = SPF_GAIN;
        `SPF_POS_GRID: kind_of = SPF_GRID;
        `SPF_POS_AMP:  kind_of = SPF_AMP;
        default:       kind_of = SPF_PULSE;
      endcase
    end
  endfunction
  function automatic logic [2:0] width_of(input logic [6:0] idx);
    case (kind_of(idx))
      SPF_LAR: begin
        case (idx[2:1])
          2'd0:    width_of = `SPF_W_LAR12;
          2'd1:    width_of = `SPF_W_LAR34;
          2'd2:    width_of = `SPF_W_LAR56;
          default: width_of = `SPF_W_LAR78;
        endcase
      end
      SPF_LAG:  width_of = `SPF_W_LAG;
      SPF_GAIN: width_of = `SPF_W_GAIN;
      SPF_GRID: width_of = `SPF_W_GRID;
      SPF_AMP:  width_of = `SPF_W_AMP;
      default:  width_of = `SPF_W_PULSE;
    endcase
  endfunction
  // any value fits once masked to its width
  function automatic logic [15:0] field_mask(input logic [6:0] idx);
    field_mask = 16'((16'h0001 << width_of(idx)) - 16'h0001);
  endfunction
  function automatic logic [3:0] slot_of(input logic [6:0] idx);
    slot_of = (idx < `SPF_LAR_WORDS) ? 4'(idx) :
              (kind_of(idx) == SPF_PULSE) ? 4'(pos_of(idx) - `SPF_PULSE_FIRST) : 4'h0;
  endfunction
  function automatic logic [1:0] sub_of(input logic [6:0] idx);
    sub_of = (idx < `SPF_LAR_WORDS) ? 2'h0 : 2'((idx - `SPF_LAR_WORDS) / `SPF_SUB_WORDS);
  endfunction
  function automatic logic [15:0] sat_add(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] sum;
    sum     = {a[15], a} + {b[15], b};
    sat_add = (sum[16] == sum[15]) ? sum[15:0] : (sum[16] ? `SPF_SAT_MIN : `SPF_SAT_MAX);
  endfunction

  // encoder side state
  logic              enc_lin_valid_ff, nxt_enc_lin_valid;
  logic [12:0]       enc_linear_ff,    nxt_enc_linear;
  logic              enc_lsb_err_ff,   nxt_enc_lsb_err;
  logic [6:0]        encp_idx_ff,      nxt_encp_idx;
  logic              encp_valid_ff,    nxt_encp_valid;
  logic [15:0]       encp_word_ff,     nxt_encp_word;
  logic              encp_last_ff,     nxt_encp_last;

  always_comb begin
    nxt_enc_lin_valid = enc_sample_valid_i;
    nxt_enc_linear    = enc_sample_valid_i ? enc_sample_i[15:3] : enc_linear_ff;
    nxt_enc_lsb_err   = enc_sample_valid_i ? (enc_sample_i[2:0] != 3'h0) : enc_lsb_err_ff;
    nxt_encp_valid = encp_valid_i;
    nxt_encp_word  = encp_valid_i ? (encp_code_i & field_mask(encp_idx_ff)) : encp_word_ff;
    nxt_encp_last  = encp_valid_i && (encp_idx_ff == `SPF_LAST_WORD);
    nxt_encp_idx   = !encp_valid_i ? encp_idx_ff :
                     (encp_idx_ff == `SPF_LAST_WORD) ? 7'h00 : 7'(encp_idx_ff + 7'h01);
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      {enc_lin_valid_ff, enc_linear_ff, enc_lsb_err_ff, encp_idx_ff} <= 22'h0;
      {encp_valid_ff, encp_word_ff, encp_last_ff}                   <= 18'h0;
    end else begin
      enc_lin_valid_ff <= nxt_enc_lin_valid;
      enc_linear_ff    <= nxt_enc_linear;
      enc_lsb_err_ff   <= nxt_enc_lsb_err;
      encp_idx_ff      <= nxt_encp_idx;
      encp_valid_ff    <= nxt_encp_valid;
      encp_word_ff     <= nxt_encp_word;
      encp_last_ff     <= nxt_encp_last;
    end
  end

  // decoder parameter side state
  logic [6:0]        dec_idx_ff,   nxt_dec_idx;
  logic              dec_valid_ff, nxt_dec_valid;
  spf_kind_t         dec_kind_ff,  nxt_dec_kind;
  logic [1:0]        dec_sub_ff,   nxt_dec_sub;
  logic [3:0]        dec_slot_ff,  nxt_dec_slot;
  logic [6:0]        dec_value_ff, nxt_dec_value;
  logic              dec_last_ff,  nxt_dec_last;
  logic              lag_bad_ff,   nxt_lag_bad;
  logic [15:0]       dec_masked;

  always_comb begin
    dec_masked    = decp_word_i & field_mask(dec_idx_ff);
    nxt_dec_valid = decp_valid_i;
    nxt_dec_kind  = dec_kind_ff;
    nxt_dec_sub   = dec_sub_ff;
    nxt_dec_slot  = dec_slot_ff;
    nxt_dec_value = dec_value_ff;
    nxt_dec_last  = 1'b0;
    nxt_lag_bad   = lag_bad_ff;
    nxt_dec_idx   = dec_idx_ff;
    if (decp_valid_i) begin
      nxt_dec_kind  = kind_of(dec_idx_ff);
      nxt_dec_sub   = sub_of(dec_idx_ff);
      nxt_dec_slot  = slot_of(dec_idx_ff);
      nxt_dec_value = dec_masked[6:0];
      nxt_dec_last  = (dec_idx_ff == `SPF_LAST_WORD);
      nxt_dec_idx   = nxt_dec_last ? 7'h00 : 7'(dec_idx_ff + 7'h01);
      // out-of-range lag flagged but passed on
      if (kind_of(dec_idx_ff) == SPF_LAG) begin
        nxt_lag_bad = (dec_masked[6:0] < `SPF_LAG_MIN) || (dec_masked[6:0] > `SPF_LAG_MAX);
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      dec_kind_ff  <= SPF_LAR;
      {dec_idx_ff, dec_valid_ff, dec_sub_ff, dec_slot_ff} <= 14'h0;
      {dec_value_ff, dec_last_ff, lag_bad_ff}             <= 9'h0;
    end else begin
      dec_idx_ff   <= nxt_dec_idx;
      dec_valid_ff <= nxt_dec_valid;
      dec_kind_ff  <= nxt_dec_kind;
      dec_sub_ff   <= nxt_dec_sub;
      dec_slot_ff  <= nxt_dec_slot;
      dec_value_ff <= nxt_dec_value;
      dec_last_ff  <= nxt_dec_last;
      lag_bad_ff   <= nxt_lag_bad;
    end
  end

  // sample pacing and output scaling
  logic [12:0]       tick_cnt_ff,    nxt_tick_cnt;
  logic [7:0]        samp_cnt_ff,    nxt_samp_cnt;
  logic [15:0]       hold_ff,        nxt_hold;
  logic              pcm_valid_ff,   nxt_pcm_valid;
  logic [15:0]       pcm_ff,         nxt_pcm;
  logic              frame_start_ff, nxt_frame_start;
  logic              tick;

  always_comb begin
    // one sample slot per 125 us
    tick         = (tick_cnt_ff == 13'(SAMPLE_CYCLES - 1));
    nxt_tick_cnt = tick ? 13'h0000 : 13'(tick_cnt_ff + 13'h0001);
    // late synth sample repeats the last one, keeping output continuous
    nxt_hold     = synth_valid_i ? synth_sample_i : hold_ff;
    nxt_pcm_valid   = tick;
    nxt_pcm         = pcm_ff;
    nxt_frame_start = 1'b0;
    nxt_samp_cnt    = samp_cnt_ff;
    if (tick) begin
      // saturating double, then clear pad bits
      nxt_pcm         = sat_add(hold_ff, hold_ff) & `SPF_PCM_MASK;
      nxt_frame_start = (samp_cnt_ff == 8'h00);
      nxt_samp_cnt    = (samp_cnt_ff == `SPF_LAST_SAMPLE) ? 8'h00 : 8'(samp_cnt_ff + 8'h01);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      {tick_cnt_ff, samp_cnt_ff, hold_ff}    <= 37'h0;
      {pcm_valid_ff, pcm_ff, frame_start_ff} <= 18'h0;
    end else begin
      tick_cnt_ff    <= nxt_tick_cnt;
      samp_cnt_ff    <= nxt_samp_cnt;
      hold_ff        <= nxt_hold;
      pcm_valid_ff   <= nxt_pcm_valid;
      pcm_ff         <= nxt_pcm;
      frame_start_ff <= nxt_frame_start;
    end
  end

  assign enc_lin_valid_o = enc_lin_valid_ff;
  assign enc_linear_o    = enc_linear_ff;
  assign enc_lsb_err_o   = enc_lsb_err_ff;
  assign encp_valid_o    = encp_valid_ff;
  assign encp_word_o     = encp_word_ff;
  assign encp_last_o     = encp_last_ff;
  assign dec_valid_o     = dec_valid_ff;
  assign dec_kind_o      = dec_kind_ff;
  assign dec_sub_o       = dec_sub_ff;
  assign dec_slot_o      = dec_slot_ff;
  assign dec_value_o     = dec_value_ff;
  assign dec_last_o      = dec_last_ff;
  assign lag_bad_o       = lag_bad_ff;
  assign pcm_valid_o     = pcm_valid_ff;
  assign pcm_o           = pcm_ff;
  assign frame_start_o   = frame_start_ff;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_last_word_in;
    decp_valid_i && (dec_idx_ff == `SPF_LAST_WORD);
  endsequence

  sequence s_frame_closed;
    dec_valid_o && dec_last_o && (dec_idx_ff == 7'h00);
  endsequence

  a_pcm_pad_zero: assert property (pcm_valid_o |-> pcm_o[2:0] == 3'h0)
    else $error("pcm pad bits not zero");
  a_enc_linear: assert property (enc_sample_valid_i |=> enc_linear_o == $past(enc_sample_i[15:3]))
    else $error("encoder linear value wrong");
  a_lar_width: assert property (dec_valid_o && dec_kind_o == SPF_LAR |->
      (dec_slot_o < 4'h2 ? dec_value_o[6] == 1'b0 :
       dec_slot_o < 4'h4 ? dec_value_o[6:5] == 2'h0 :
       dec_slot_o < 4'h6 ? dec_value_o[6:4] == 3'h0 : dec_value_o[6:3] == 4'h0))
    else $error("ratio code too wide");
  a_subframe_width: assert property (dec_valid_o && (dec_kind_o == SPF_GAIN ||
      dec_kind_o == SPF_GRID) |-> dec_value_o[6:2] == 5'h00)
    else $error("gain or grid code too wide");
  a_pulse_width: assert property (dec_valid_o && dec_kind_o == SPF_PULSE |->
      dec_value_o[6:3] == 4'h0 && dec_slot_o <= `SPF_LAST_PULSE)
    else $error("pulse code wrong");
  a_frame_wrap: assert property (s_last_word_in |=> s_frame_closed)
    else $error("frame did not close after 76 words");
  a_frame_order: assert property (s_last_word_in ##1 s_frame_closed |->
      dec_kind_o == SPF_PULSE && dec_sub_o == `SPF_LAST_SUB && dec_slot_o == `SPF_LAST_PULSE)
    else $error("last word not final pulse");
  a_lag_passed: assert property (decp_valid_i && kind_of(dec_idx_ff) == SPF_LAG |=>
      dec_kind_o == SPF_LAG && dec_value_o == $past(decp_word_i[6:0]) &&
      lag_bad_o == (dec_value_o < `SPF_LAG_MIN || dec_value_o > `SPF_LAG_MAX))
    else $error("lag code not passed as received");
  a_sample_pace: assert property (pcm_valid_o |-> tick_cnt_ff == 13'h0000 ##1 !pcm_valid_o)
    else $error("sample pacing broken");
  a_sat_high: assert property ($signed(hold_ff) >= $signed(`SPF_HALF_RANGE) && tick |=>
      pcm_o == `SPF_PCM_SAT_MAX)
    else $error("positive overflow not saturated");

endmodule

// file: common/spf_map.svh
`ifndef SPF_MAP_SVH
`define SPF_MAP_SVH

// frame layout in coded-parameter words
`define SPF_FRAME_WORDS     7'd76
`define SPF_LAST_WORD       7'd75
`define SPF_LAR_WORDS       7'd8
`define SPF_SUB_WORDS       7'd17
`define SPF_POS_LAG         7'd0
`define SPF_POS_GAIN        7'd1
`define SPF_POS_GRID        7'd2
`define SPF_POS_AMP         7'd3
`define SPF_PULSE_FIRST     7'd4
`define SPF_LAST_PULSE      4'd12
`define SPF_LAST_SUB        2'd3

// field widths in bits
`define SPF_W_LAR12         3'd6
`define SPF_W_LAR34         3'd5
`define SPF_W_LAR56         3'd4
`define SPF_W_LAR78         3'd3
`define SPF_W_LAG           3'd7
`define SPF_W_GAIN          3'd2
`define SPF_W_GRID          3'd2
`define SPF_W_AMP           3'd6
`define SPF_W_PULSE         3'd3

// lag range produced by an error-free encoder
`define SPF_LAG_MIN         7'd40
`define SPF_LAG_MAX         7'd120

// sample word format
`define SPF_PCM_MASK        16'hFFF8
`define SPF_SAT_MAX         16'h7FFF
`define SPF_SAT_MIN         16'h8000
`define SPF_PCM_SAT_MAX     16'h7FF8
`define SPF_HALF_RANGE      16'h4000

// timing
`define SPF_CLK_PERIOD_NS    25
`define SPF_SAMPLE_PERIOD_NS 125000
`define SPF_LAST_SAMPLE      8'd159

`endif

// file: common/spf_pkg.sv
package spf_pkg;

  typedef enum logic [2:0] {
    SPF_LAR,
    SPF_LAG,
    SPF_GAIN,
    SPF_GRID,
    SPF_AMP,
    SPF_PULSE
  } spf_kind_t;

endpackage

// file: tb/spf_dec_feed.sv
`timescale 1ns/1ps
module spf_dec_feed (
  input  wire logic        mclk_i,
  output logic             valid_o,
  output logic [15:0]      word_o
);
  int seed = 28444;

  function automatic int fw(input int i);
    int q;
    q = (i - 8) % 17;
    if (i < 8) return (i < 2) ? 6 : (i < 4) ? 5 : (i < 6) ? 4 : 3;
    return (q == 0) ? 7 : (q == 3) ? 6 : (q < 3) ? 2 : 3;
  endfunction

  initial begin
    valid_o = 1'b0;
    word_o  = 16'h0000;
  end

  // mode 0 random, 1 any lag, 2 all ones, 3 all zero; lag >= 0 forces the lag
  // fixed frame order
  task automatic send(input int mode, input int lag);
    int i;
    int m;
    logic [15:0] v;
    for (i = 0; i < 76; i++) begin
      m = (1 << fw(i)) - 1;
      v = (mode == 2) ? 16'(m) : (mode == 3) ? 16'h0000 : 16'($random(seed)) & 16'(m);
      if (i >= 8 && (i - 8) % 17 == 0) begin
        if (lag >= 0) v = 16'(lag);
        else if (mode == 1) v = 16'($random(seed)) & 16'h007F;
        else v = 16'(40 + {$random(seed)} % 81);
      end
      @(negedge mclk_i);
      valid_o = 1'b1;
      word_o  = v;
    end
    @(negedge mclk_i);
    valid_o = 1'b0;
    // released bus shows the inverse so a stale word never passes
    word_o  = ~word_o;
  endtask
endmodule

// file: tb/tb.sv
`timescale 1ns/1ps
`include "spf_map.svh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_count++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, a, b); end end
module tb;
  import spf_pkg::*;
  localparam int SC = 8;
  logic mclk_i = 0, reset_n_i = 0, enc_sample_valid_i = 0, encp_valid_i = 0, synth_valid_i = 0;
  logic [15:0] enc_sample_i = 0, encp_code_i = 0, synth_sample_i = 0, decp_word_i;
  logic decp_valid_i, enc_lin_valid_o, enc_lsb_err_o, encp_valid_o, encp_last_o, dec_valid_o;
  logic dec_last_o, lag_bad_o, pcm_valid_o, frame_start_o;
  logic [12:0] enc_linear_o;
  logic [15:0] encp_word_o, pcm_o;
  spf_kind_t   dec_kind_o, dk;
  logic [1:0]  dec_sub_o, ds;
  logic [3:0]  dec_slot_o, dsl;
  logic [6:0]  dec_value_o, dval;
  logic ev, ee, pv, pl, dv, dl, lbq;
  logic [12:0] el;
  logic [15:0] pw, held, hp, v;
  int err_count = 0, samples_checked = 0, seed = 28444, ei, di, gap, npcm, q, k;

  spf_format #(.SAMPLE_CYCLES(SC)) spf_format_i (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .enc_sample_valid_i(enc_sample_valid_i),
    .enc_sample_i(enc_sample_i), .encp_valid_i(encp_valid_i), .encp_code_i(encp_code_i),
    .decp_valid_i(decp_valid_i), .decp_word_i(decp_word_i), .synth_valid_i(synth_valid_i),
    .synth_sample_i(synth_sample_i), .enc_lin_valid_o(enc_lin_valid_o),
    .enc_linear_o(enc_linear_o), .enc_lsb_err_o(enc_lsb_err_o), .encp_valid_o(encp_valid_o),
    .encp_word_o(encp_word_o), .encp_last_o(encp_last_o), .dec_valid_o(dec_valid_o),
    .dec_kind_o(dec_kind_o), .dec_sub_o(dec_sub_o), .dec_slot_o(dec_slot_o),
    .dec_value_o(dec_value_o), .dec_last_o(dec_last_o), .lag_bad_o(lag_bad_o),
    .pcm_valid_o(pcm_valid_o), .pcm_o(pcm_o), .frame_start_o(frame_start_o));
  spf_dec_feed spf_dec_feed_i (.mclk_i(mclk_i), .valid_o(decp_valid_i), .word_o(decp_word_i));

  function automatic int fw(input int i);
    int r;
    r = (i - 8) % 17;
    if (i < 8) return (i < 2) ? 6 : (i < 4) ? 5 : (i < 6) ? 4 : 3;
    return (r == 0) ? 7 : (r == 3) ? 6 : (r < 3) ? 2 : 3;
  endfunction

  function automatic logic [15:0] pcm_fn(input logic [15:0] s);
    logic signed [16:0] d;
    d = $signed({s[15], s}) * 2;
    if (d > 17'sd32767) return `SPF_PCM_SAT_MAX;
    if (d < -17'sd32768) return `SPF_SAT_MIN;
    return d[15:0] & `SPF_PCM_MASK;
  endfunction

  task summarize;
    $display("checks=%0d errors=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    forever #12.5 mclk_i = ~mclk_i;
  end

  // expectations one edge ahead of the registered outputs
  always @(posedge mclk_i) begin
    if (!reset_n_i) begin
      {ev, pv, dv, lbq} = 4'h0;
      {ei, di, gap, npcm, held, hp} = 0;
    end else begin
      gap++;
      `CHK(enc_lin_valid_o, ev)
      if (ev) begin
        `CHK(enc_linear_o, el)
        `CHK(enc_lsb_err_o, ee)
      end
      `CHK(encp_valid_o, pv)
      if (pv) begin
        `CHK(encp_word_o, pw)
        `CHK(encp_last_o, pl)
      end
      `CHK(dec_valid_o, dv)
      `CHK(lag_bad_o, lbq)
      if (dv) begin
        `CHK(dec_kind_o, dk)
        `CHK(dec_sub_o, ds)
        `CHK(dec_slot_o, dsl)
        `CHK(dec_value_o, dval)
        `CHK(dec_last_o, dl)
      end
      if (pcm_valid_o) begin
        `CHK(pcm_o, pcm_fn(hp))
        if (npcm > 0) `CHK(gap, SC)
        `CHK(frame_start_o, 1'(npcm % 160 == 0))
        npcm++;
        gap = 0;
      end
      ev = enc_sample_valid_i;
      if (ev) {el, ee} = {enc_sample_i[15:3], |enc_sample_i[2:0]};
      pv = encp_valid_i;
      if (pv) begin
        pw = encp_code_i & 16'((1 << fw(ei)) - 1);
        pl = (ei == 75);
        ei = pl ? 0 : ei + 1;
      end
      dv = decp_valid_i;
      if (dv) begin
        q = (di - 8) % 17;
        dval = 7'(decp_word_i & 16'((1 << fw(di)) - 1));
        dk = (di < 8) ? SPF_LAR : (q == 0) ? SPF_LAG : (q == 1) ? SPF_GAIN :
             (q == 2) ? SPF_GRID : (q == 3) ? SPF_AMP : SPF_PULSE;
        ds = (di < 8) ? 2'd0 : 2'((di - 8) / 17);
        dsl = (di < 8) ? 4'(di) : (q >= 4) ? 4'(q - 4) : 4'd0;
        dl = (di == 75);
        if (dk == SPF_LAG) lbq = (dval < `SPF_LAG_MIN) || (dval > `SPF_LAG_MAX);
        di = dl ? 0 : di + 1;
      end
      hp = held;
      if (synth_valid_i) held = synth_sample_i;
    end
  end

  task do_reset;
    @(negedge mclk_i);
    {reset_n_i, enc_sample_valid_i, encp_valid_i, synth_valid_i} = 4'h0;
    repeat (6) @(negedge mclk_i);
    reset_n_i = 1'b1;
  endtask

  task wait_pcm;
    int n;
    n = 0;
    while (pcm_valid_o !== 1'b1 && n < 4 * SC) begin
      @(negedge mclk_i);
      n++;
    end
    if (n >= 4 * SC) begin
      err_count++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, 0, 1);
      summarize();
    end
  endtask

  initial begin
    do_reset();
    @(negedge mclk_i);
    `CHK(dec_kind_o, SPF_LAR)
    `CHK(pcm_o, 16'h0000)
    // back-to-back samples, pad bits both clean and dirty
    for (k = 0; k < 40; k++) begin
      @(negedge mclk_i);
      enc_sample_valid_i = 1'b1;
      enc_sample_i = (k == 0) ? 16'hFFF8 : (k == 1) ? 16'h0008 : 16'($random(seed));
    end
    // partial frame, then reset mid-frame must restart the word index
    for (k = 0; k < 182; k++) begin
      if (k == 30) do_reset();
      @(negedge mclk_i);
      enc_sample_valid_i = 1'b0;
      encp_valid_i = 1'b1;
      encp_code_i = (k % 19 == 0) ? 16'hFFFF : 16'($random(seed));
    end
    @(negedge mclk_i);
    encp_valid_i = 1'b0;
    // saturation corners, then random
    for (k = 0; k < 24; k++) begin
      case (k)
        0: v = 16'h4000;
        1: v = 16'h3FFF;
        2: v = 16'hC000;
        3: v = 16'hBFFF;
        4: v = 16'h8000;
        5: v = 16'h7FFF;
        6: v = 16'hFFFF;
        default: v = 16'($random(seed));
      endcase
      wait_pcm();
      repeat (k % 3) @(negedge mclk_i);
      synth_valid_i = 1'b1;
      synth_sample_i = v;
      @(negedge mclk_i);
      synth_valid_i = 1'b0;
    end
    // lag codes inside and outside the error-free range, field extremes
    spf_dec_feed_i.send(0, -1);
    spf_dec_feed_i.send(1, -1);
    spf_dec_feed_i.send(2, 127);
    spf_dec_feed_i.send(3, 0);
    spf_dec_feed_i.send(0, 39);
    spf_dec_feed_i.send(0, 40);
    spf_dec_feed_i.send(0, 120);
    spf_dec_feed_i.send(0, 121);
    // repeated samples with no new synth input, past a frame boundary
    repeat (1400) @(negedge mclk_i);
    summarize();
  end
endmodule
